// ---- verilog/baud_timer_pkg.sv ----
// package for the auto-reload / baud-rate timer
package baud_timer_pkg;
   localparam int unsigned CNT_W        = 16;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   // overflows are halved into the baud tick (x2 of the 1/32 divisor)
   localparam int unsigned BAUD_DIV     = 2;

   typedef enum logic {
      MODE_AUTO_RELOAD,
      MODE_BAUD_GEN
   } timer_mode_e;

   // control bits from the cpu side
   typedef struct packed {
      logic rx_baud_select;
      logic tx_baud_select;
      logic run_control;
      logic capture_reload_select;
      logic counter_timer_select;
      logic external_event_enable;
      logic clock_out_enable;
      logic down_count_enable;
   } timer_ctrl_s;

   // byte writes from the cpu side
   typedef struct packed {
      logic       wr_count_low;
      logic       wr_count_high;
      logic       wr_reload_low;
      logic       wr_reload_high;
      logic       set_flag;
      logic       clr_flag;
      logic [7:0] wdata;
   } timer_wr_s;
endpackage

// ---- verilog/auto_reload_baud_timer.sv ----
// 16-bit auto-reload timer with baud-rate generator mode
`timescale 1ns/1ns
`default_nettype none
module auto_reload_baud_timer
   import baud_timer_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire timer_ctrl_s ctrl_i,
   input  wire timer_wr_s   wr_i,
   input  wire logic        global_irq_enable_i,
   input  wire logic        timer_irq_enable_i,
   input  wire logic        alt_baud_tick_i,
   output logic      [15:0] count_o,
   output logic      [15:0] reload_o,
   output logic             overflow_flag_o,
   output logic             irq_o,
   output logic             rx_baud_tick_o,
   output logic             tx_baud_tick_o
);

   ////////////////////////////////////////////////////////////////
   timer_mode_e mode;
   logic [15:0] count_r, count_nxt;
   logic [15:0] reload_r, reload_nxt;
   logic        flag_r, flag_nxt;
   logic        half_r, half_nxt;
   logic        tick_r, tick_nxt;
   logic        irq_r, irq_nxt;
   logic        rxt_r, rxt_nxt;
   logic        txt_r, txt_nxt;
   logic        ovf;

   always_comb begin
      if (ctrl_i.rx_baud_select || ctrl_i.tx_baud_select) begin
         mode = MODE_BAUD_GEN;
      end else begin
         mode = MODE_AUTO_RELOAD;
      end
   end

   // overflow needs run, so a stopped count parked at FFFF never reloads
   // run gate
   assign ovf = ctrl_i.run_control && (count_r == CNT_MAX);

   ////////////////////////////////////////////////////////////////
   always_comb begin
      count_nxt  = count_r;
      reload_nxt = reload_r;
      if (ctrl_i.run_control) begin
         count_nxt = count_r + 16'h0001;
      end
      if (ovf) begin
         count_nxt = reload_r;
      end
      // byte write applied last so software always sees its value land
      // cpu byte write wins over count
      if (wr_i.wr_count_low) begin
         count_nxt[7:0] = wr_i.wdata;
      end
      if (wr_i.wr_count_high) begin
         count_nxt[15:8] = wr_i.wdata;
      end
      // no guard here: reload writes in baud mode just disturb the rate
      if (wr_i.wr_reload_low) begin
         reload_nxt[7:0] = wr_i.wdata;
      end
      if (wr_i.wr_reload_high) begin
         reload_nxt[15:8] = wr_i.wdata;
      end
   end

   // no hardware set in baud mode
   always_comb begin
      flag_nxt = flag_r;
      if (wr_i.clr_flag) begin
         flag_nxt = 1'b0;
      end
      if (wr_i.set_flag || (ovf && mode == MODE_AUTO_RELOAD)) begin
         flag_nxt = 1'b1;
      end
   end

   always_comb begin
      irq_nxt = flag_r && global_irq_enable_i && timer_irq_enable_i;
   end

   // divide overflows by two; serial port divides by 16
   always_comb begin
      half_nxt = half_r;
      tick_nxt = 1'b0;
      if (ovf && mode == MODE_BAUD_GEN) begin
         half_nxt = ~half_r;
         tick_nxt = half_r;
      end
   end

   // own tick leaves two edges after its overflow, alt ticks one edge late
   // route each direction
   always_comb begin
      if (ctrl_i.rx_baud_select) begin
         rxt_nxt = tick_r;
      end else begin
         rxt_nxt = alt_baud_tick_i;
      end
      if (ctrl_i.tx_baud_select) begin
         txt_nxt = tick_r;
      end else begin
         txt_nxt = alt_baud_tick_i;
      end
   end

   ////////////////////////////////////////////////////////////////
   // one bank of flops; every output leaves straight from here
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count_r  <= CNT_RESET;
         reload_r <= RELOAD_RESET;
         flag_r   <= 1'b0;
         half_r   <= 1'b0;
         tick_r   <= 1'b0;
         irq_r    <= 1'b0;
         rxt_r    <= 1'b0;
         txt_r    <= 1'b0;
      end else begin
         count_r  <= count_nxt;
         reload_r <= reload_nxt;
         flag_r   <= flag_nxt;
         half_r   <= half_nxt;
         tick_r   <= tick_nxt;
         irq_r    <= irq_nxt;
         rxt_r    <= rxt_nxt;
         txt_r    <= txt_nxt;
      end
   end

   assign count_o         = count_r;
   assign reload_o        = reload_r;
   assign overflow_flag_o = flag_r;
   assign irq_o           = irq_r;
   assign rx_baud_tick_o  = rxt_r;
   assign tx_baud_tick_o  = txt_r;

   ////////////////////////////////////////////////////////////////
   chk_reload_on_ovf: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ovf && !wr_i.wr_count_low && !wr_i.wr_count_high) |=> count_r == $past(reload_r))
      else $error("counter not reloaded on overflow");
   chk_flag_set_ovf: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ovf && mode == MODE_AUTO_RELOAD) |=> flag_r)
      else $error("overflow flag not set");
   chk_flag_baud_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!flag_r && !wr_i.set_flag && mode == MODE_BAUD_GEN) |=> !flag_r)
      else $error("flag set in baud mode");
   chk_flag_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (flag_r && !wr_i.clr_flag) |=> flag_r)
      else $error("flag dropped without clear");
   chk_irq_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
      irq_r == $past(flag_r && global_irq_enable_i && timer_irq_enable_i))
      else $error("irq not gated correctly");
   chk_run_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!ctrl_i.run_control && !wr_i.wr_count_low && !wr_i.wr_count_high)
      |=> $stable(count_r))
      else $error("counter moved while stopped");
   chk_count_up: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ctrl_i.run_control && !ovf && !wr_i.wr_count_low && !wr_i.wr_count_high)
      |=> count_r == $past(count_r) + 16'h0001)
      else $error("counter did not increment");
   chk_low_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i.wr_count_low |=> count_r[7:0] == $past(wr_i.wdata))
      else $error("low byte write lost");
   chk_baud_tick: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ovf && mode == MODE_BAUD_GEN && half_r) ##1 ctrl_i.rx_baud_select
      |=> rx_baud_tick_o)
      else $error("rx baud tick missing");
   chk_baud_tick_tx: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ovf && mode == MODE_BAUD_GEN && half_r) ##1 ctrl_i.tx_baud_select
      |=> tx_baud_tick_o)
      else $error("tx baud tick missing");
   chk_half_toggle: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ovf && mode == MODE_BAUD_GEN) |=> half_r != $past(half_r))
      else $error("baud divider did not toggle");
   chk_high_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i.wr_count_high |=> count_r[15:8] == $past(wr_i.wdata))
      else $error("high byte write lost");
   chk_reload_low_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i.wr_reload_low |=> reload_r[7:0] == $past(wr_i.wdata))
      else $error("reload low byte write lost");
   chk_reload_high_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i.wr_reload_high |=> reload_r[15:8] == $past(wr_i.wdata))
      else $error("reload high byte write lost");
   chk_rx_alt_route: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !ctrl_i.rx_baud_select |=> rx_baud_tick_o == $past(alt_baud_tick_i))
      else $error("rx alternate tick not forwarded");
   chk_tx_alt_route: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !ctrl_i.tx_baud_select |=> tx_baud_tick_o == $past(alt_baud_tick_i))
      else $error("tx alternate tick not forwarded");
   chk_baud_no_irq: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!flag_r && !wr_i.set_flag && mode == MODE_BAUD_GEN) |=> ##1 !irq_o)
      else $error("interrupt raised by baud overflow");

endmodule
`default_nettype wire

// ---- dv/baud_consumer_model.sv ----
// serial port side model: tallies baud ticks per direction
`timescale 1ns/1ns
`default_nettype none
module baud_consumer_model (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        rx_tick_i,
   input  wire logic        tx_tick_i,
   output logic      [31:0] rx_cnt_o,
   output logic      [31:0] tx_cnt_o
);
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_cnt_o <= '0;
         tx_cnt_o <= '0;
      end else begin
         rx_cnt_o <= rx_cnt_o + 32'(rx_tick_i);
         tx_cnt_o <= tx_cnt_o + 32'(tx_tick_i);
      end
   end
endmodule
`default_nettype wire

// ---- dv/auto_reload_baud_timer_test.sv ----
// self-checking bench for the auto-reload / baud timer
`timescale 1ns/1ns
`default_nettype none
module auto_reload_baud_timer_test import baud_timer_pkg::*;;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   timer_ctrl_s ctrl = '0;
   timer_wr_s   wr = '0;
   logic        gie = 1'b1;
   logic        tie = 1'b1;
   logic        alt = 1'b0;
   logic [15:0] cnt, rld, r;
   logic        flg, irq, rxt, txt, prv, sel;
   logic [31:0] rxn, txn, base, seed = 32'hC8F9A42E;
   int          err_total = 0, num_checks = 0, cyc = 0, w;
   always #25 clk = ~clk;
   auto_reload_baud_timer u_dut (.clk_i(clk), .rstn_i(rstn), .ctrl_i(ctrl), .wr_i(wr),
      .global_irq_enable_i(gie), .timer_irq_enable_i(tie), .alt_baud_tick_i(alt),
      .count_o(cnt), .reload_o(rld), .overflow_flag_o(flg), .irq_o(irq),
      .rx_baud_tick_o(rxt), .tx_baud_tick_o(txt));
   baud_consumer_model u_far (.clk_i(clk), .rstn_i(rstn), .rx_tick_i(rxt),
      .tx_tick_i(txt), .rx_cnt_o(rxn), .tx_cnt_o(txn));
   ////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // ticks seen in a window of w cycles
   function automatic logic [31:0] exp_ticks(input logic [15:0] rv, input int wn);
      return 32'(wn / (int'(BAUD_DIV) * (65536 - int'(rv))));
   endfunction
   task automatic summarize;
      if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_v(input logic [31:0] a, input logic [31:0] e);
      num_checks++;
      if (a !== e) begin
         err_total++;
         $display("Error %0t: value %h want %h", $time, a, e);
      end
   endtask
   task automatic chk_b(input logic a, input logic e);
      num_checks++;
      if (a !== e) begin
         err_total++;
         $display("Error %0t: bit %b want %b", $time, a, e);
      end
   endtask
   // strobe held one cycle, then a gap so no double drive
   task automatic put(input logic [5:0] k, input logic [7:0] d);
      @(posedge clk);
      wr <= {k, d};
      @(posedge clk);
      wr <= '0;
   endtask
   task automatic ld(input logic [15:0] rv, input logic [15:0] c);
      put(6'h08, rv[7:0]);
      put(6'h04, rv[15:8]);
      put(6'h20, c[7:0]);
      put(6'h10, c[15:8]);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk_v(32'(cnt), 32'(CNT_RESET));
      chk_v(32'(rld), 32'(RELOAD_RESET));
      chk_b(flg, 1'b0);
      ld(16'hFFFE, 16'hFFFE);
      @(posedge clk);
      ctrl.run_control <= 1'b1;
      @(negedge clk);
      chk_v(32'(rld), 32'h0000FFFE);
      @(negedge clk);
      chk_v(32'(cnt), 32'h0000FFFF);
      @(negedge clk);
      chk_v(32'(cnt), 32'h0000FFFE);
      chk_b(flg, 1'b1);
      chk_b(irq, 1'b0);
      @(negedge clk);
      chk_b(irq, 1'b1);
      put(6'h10, 8'h12);
      @(negedge clk);
      chk_v(32'(cnt[15:8]), 32'h00000012);
      @(posedge clk);
      ctrl.run_control <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      base = 32'(cnt);
      repeat (3) @(negedge clk);
      chk_v(32'(cnt), base);
      chk_b(flg, 1'b1);
      for (int i = 0; i < 4; i++) begin
         put(6'h01, 8'h00);
         @(negedge clk);
         chk_b(flg, 1'b0);
         @(posedge clk);
         {gie, tie} <= 2'(i);
         put(6'h02, 8'h00);
         repeat (2) @(negedge clk);
         chk_b(irq, i == 3);
      end
      put(6'h01, 8'h00);
      // first pass is the every-cycle overflow corner
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         r = (i == 0) ? 16'hFFFF : {12'hFFF, seed[3:0]};
         sel = seed[4];
         @(posedge clk);
         ctrl <= '0;
         ld(r, r);
         // config bits stay zero in baud mode
         ctrl.rx_baud_select <= sel;
         ctrl.tx_baud_select <= ~sel;
         ctrl.run_control <= 1'b1;
         repeat (5) @(negedge clk);
         base = sel ? rxn : txn;
         w = int'(BAUD_DIV) * (65536 - int'(r)) * 4;
         for (int k = 0; k < w; k++) begin
            @(posedge clk);
            prv = alt;
            seed = xs(seed);
            alt <= seed[0];
            @(negedge clk);
            chk_b(sel ? txt : rxt, prv);
            chk_b(flg, 1'b0);
         end
         chk_v((sel ? rxn : txn) - base, exp_ticks(r, w));
         chk_b(irq, 1'b0);
      end
      // mid-run reset: state clears, count restarts from zero
      @(posedge clk);
      rstn <= 1'b0;
      @(negedge clk);
      chk_v({rld, cnt}, {RELOAD_RESET, CNT_RESET});
      chk_b(flg | irq | rxt | txt, 1'b0);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(negedge clk);
      chk_v(32'(cnt), 32'h00000001);
      summarize();
   end
endmodule
`default_nettype wire
